// File: design/fprt_params.svh
// Purpose: constants of the fan pwm ramp and tach monitor
// Assumes: 25 MHz core clock, apb index = byte address / 4
// Notes:   definitions only
`ifndef FPRT_PARAMS_SVH
`define FPRT_PARAMS_SVH
// register indices
`define FPRT_IDX_SEC      8'ha7
`define FPRT_IDX_TMODE    8'hab
`define FPRT_IDX_TEST     8'had
`define FPRT_IDX_TOPZ1    8'hae
`define FPRT_IDX_TOPZ3    8'haf
`define FPRT_IDX_TOPZ2    8'hb3
`define FPRT_IDX_TOPT     8'h90
`define FPRT_IDX_POPT     8'h94
`define FPRT_IDX_READ     8'h60
`define FPRT_IDX_LIMIT    8'h64
`define FPRT_IDX_DUTY     8'h68
`define FPRT_IDX_FSTAT    8'h6c
// reset values
`define FPRT_RST_SEC      8'h00
`define FPRT_RST_TMODE    8'h00
`define FPRT_TEST_VAL     8'h00
`define FPRT_RST_TOP      8'h2d
`define FPRT_RST_LIMIT    16'hffff
`define FPRT_RD_SLOW      16'hfffe
`define FPRT_RD_STOP      16'hffff
// field positions
`define FPRT_SEC_BATT     1
`define FPRT_SEC_STBY     0
`define FPRT_TO_SLOW      0
`define FPRT_TO_EDGE      1
`define FPRT_TO_MODE2     3
`define FPRT_TO_OPP       4
`define FPRT_TO_UPD       5
`define FPRT_TO_SEN       7
`define FPRT_PO_RR        0
`define FPRT_PO_GOFF      3
// timing
`define FPRT_CLK_HZ       25000000
`define FPRT_TACH_HZ      90000
`define FPRT_MS_PER_S     1000
`define FPRT_UPD0_MS      300
`define FPRT_UPD1_MS      500
`define FPRT_UPD2_MS      1000
`define FPRT_STEP0_MS     206
`define FPRT_STEP1_MS     104
`define FPRT_STEP2_MS     69
`define FPRT_STEP3_MS     41
`define FPRT_STEP4_MS     26
`define FPRT_STEP5_MS     18
`define FPRT_STEP6_MS     10
`define FPRT_STEP7_MS     5
`endif

// File: design/fprt_pkg.sv
// Purpose: types of the fan pwm ramp and tach monitor
// Assumes: nothing
// Notes:   one-hot tach measurement states
package fprt_pkg;
  typedef enum logic [3:0] {
    FPRT_T_WAIT  = 4'b0001,
    FPRT_T_GUARD = 4'b0010,
    FPRT_T_MEAS  = 4'b0100,
    FPRT_T_DONE  = 4'b1000
  } fprt_tst_t;
  typedef logic [7:0]  fprt_byte_t;
  typedef logic [15:0] fprt_word_t;
endpackage

// File: design/fprt_top.sv
// Purpose: pwm duty ramp limiter and tach monitor, apb registers
// Assumes: tach n is linked to pwm n; target duty from fan control
// Notes:   no interrupt output; status bits are sticky only
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`include "fprt_params.svh"
module fprt_top #(
  parameter int MS_CYC    = `FPRT_CLK_HZ / `FPRT_MS_PER_S,
  parameter int PWM_DIV   = 4,
  parameter int GUARD_TKS = 8
) (
  // clock, reset
  input  wire logic              i_core_clk,
  input  wire logic              i_arst_n,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // fan control and pins
  input  wire fprt_pkg::fprt_byte_t i_target_duty [3],
  input  wire logic [2:0]        i_tach,
  output logic      [2:0]        o_pwm,
  // supply events
  input  wire logic              i_supply_power_good,
  input  wire logic              i_batt_event,
  input  wire logic              i_standby_supply_event
);
  import fprt_pkg::*;

  localparam int TACH_CYC = `FPRT_CLK_HZ / `FPRT_TACH_HZ;

  // counters are 16, 8 and 8 bits wide
  if (MS_CYC < 1 || PWM_DIV < 1 || GUARD_TKS < 1 ||
      MS_CYC > 65536 || PWM_DIV > 256 || GUARD_TKS > 256) begin : g_chk
    $error("fprt_top: counts out of range");
  end

  function automatic logic [7:0] step_ms(input logic [2:0] rr);
    unique case (rr)
      3'd0: step_ms = 8'(`FPRT_STEP0_MS);
      3'd1: step_ms = 8'(`FPRT_STEP1_MS);
      3'd2: step_ms = 8'(`FPRT_STEP2_MS);
      3'd3: step_ms = 8'(`FPRT_STEP3_MS);
      3'd4: step_ms = 8'(`FPRT_STEP4_MS);
      3'd5: step_ms = 8'(`FPRT_STEP5_MS);
      3'd6: step_ms = 8'(`FPRT_STEP6_MS);
      3'd7: step_ms = 8'(`FPRT_STEP7_MS);
    endcase
  endfunction

  function automatic logic [9:0] upd_ms(input logic [1:0] s);
    unique case (s)
      2'd0:    upd_ms = 10'(`FPRT_UPD0_MS);
      2'd1:    upd_ms = 10'(`FPRT_UPD1_MS);
      default: upd_ms = 10'(`FPRT_UPD2_MS);
    endcase
  endfunction

  function automatic logic [3:0] span(input logic [1:0] s);
    unique case (s)
      2'd0: span = 4'd2;
      2'd1: span = 4'd3;
      2'd2: span = 4'd5;
      2'd3: span = 4'd9;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  sec_stat;
  logic [7:0]  tmode;
  logic [7:0]  top [3];
  logic [7:0]  topt [3];
  logic [7:0]  popt [3];
  logic [15:0] limit [3];
  logic [15:0] reading [3];
  logic [2:0]  fstat;
  logic [7:0]  ramp [3];
  logic [7:0]  tgt_q [3];

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] tach_s1;
  logic [2:0] tach_s2;
  logic [2:0] tach_s3;
  logic [2:0] tach_q;
  logic [2:0] pg_s;
  logic       pg_q;
  logic [2:0] bat_s;
  logic [2:0] stb_s;
  logic       bat_lv;
  logic       stb_lv;
  logic [2:0] tach_edge;
  logic       pg_rise;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tach_s1 <= '0;
      tach_s2 <= '0;
      tach_s3 <= '0;
      tach_q  <= '0;
      pg_s    <= '0;
      pg_q    <= 1'b0;
      bat_s   <= '0;
      stb_s   <= '0;
      bat_lv  <= 1'b0;
      stb_lv  <= 1'b0;
    end else begin
      tach_s1 <= i_tach;
      tach_s2 <= tach_s1;
      tach_s3 <= tach_s2;
      pg_s    <= {pg_s[1:0], i_supply_power_good};
      bat_s   <= {bat_s[1:0], i_batt_event};
      stb_s   <= {stb_s[1:0], i_standby_supply_event};
      for (int i = 0; i < 3; i++) begin
        if (tach_s2[i] == tach_s3[i]) begin
          tach_q[i] <= tach_s3[i];
        end
      end
      if (pg_s[1] == pg_s[2]) begin
        pg_q <= pg_s[2];
      end
      if (bat_s[1] == bat_s[2]) begin
        bat_lv <= bat_s[2];
      end
      if (stb_s[1] == stb_s[2]) begin
        stb_lv <= stb_s[2];
      end
    end
  end

  // tach: both transitions are edges; power good: rising edge only
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      tach_edge[i] = (tach_s2[i] == tach_s3[i]) &&
                     (tach_s3[i] != tach_q[i]);
    end
    pg_rise = (pg_s[1] == pg_s[2]) && pg_s[2] && !pg_q;
  end

  ////////////////////////////////////////////////////////////////////
  // prescalers: 1 ms, 90 khz, pwm count
  logic [15:0] ms_cnt;
  logic [8:0]  tk_cnt;
  logic [7:0]  pd_cnt;
  logic [7:0]  pwm_cnt;
  logic        ms_tick;
  logic        tk_tick;
  logic        pwm_tick;
  logic        per_start;

  assign ms_tick   = ms_cnt == 16'(MS_CYC - 1);
  assign tk_tick   = tk_cnt == 9'(TACH_CYC - 1);
  assign pwm_tick  = pd_cnt == 8'(PWM_DIV - 1);
  assign per_start = pwm_tick && pwm_cnt == 8'd254;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ms_cnt  <= '0;
      tk_cnt  <= '0;
      pd_cnt  <= '0;
      pwm_cnt <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 16'd1;
      tk_cnt <= tk_tick ? '0 : tk_cnt + 9'd1;
      pd_cnt <= pwm_tick ? '0 : pd_cnt + 8'd1;
      if (pwm_tick) begin
        pwm_cnt <= (pwm_cnt == 8'd254) ? '0 : pwm_cnt + 8'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ramp limiter and pwm outputs
  logic [7:0] st_ms [3];
  logic [7:0] pend [3];
  logic [7:0] duty_o [3];

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 3; i++) begin
        st_ms[i]  <= '0;
        pend[i]   <= '0;
        ramp[i]   <= '0;
        tgt_q[i]  <= '0;
        duty_o[i] <= '0;
      end
      o_pwm <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        tgt_q[i] <= i_target_duty[i];
        if (ms_tick) begin
          if (st_ms[i] >= step_ms(popt[i][`FPRT_PO_RR+:3]) - 8'd1)
          begin
            st_ms[i] <= '0;
            if (pend[i] != 8'hff) begin
              pend[i] <= pend[i] + 8'd1;
            end
          end else begin
            st_ms[i] <= st_ms[i] + 8'd1;
          end
        end
        if (tgt_q[i] == '0 && i_target_duty[i] != '0) begin
          ramp[i] <= i_target_duty[i];
          pend[i] <= '0;
        end else if (i_target_duty[i] == '0 &&
                     !popt[i][`FPRT_PO_GOFF]) begin
          ramp[i] <= '0;
        end else if (per_start && pend[i] != '0) begin
          // whole steps elapsed, clipped at target
          pend[i] <= '0;
          if (ramp[i] < i_target_duty[i]) begin
            ramp[i] <= (i_target_duty[i] - ramp[i] > pend[i]) ?
                       ramp[i] + pend[i] : i_target_duty[i];
          end else if (ramp[i] > i_target_duty[i]) begin
            ramp[i] <= (ramp[i] - i_target_duty[i] > pend[i]) ?
                       ramp[i] - pend[i] : i_target_duty[i];
          end
        end
        if (per_start) begin
          duty_o[i] <= ramp[i];
        end
        o_pwm[i] <= duty_o[i] > pwm_cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // tach monitors
  fprt_tst_t   tst [3];
  logic [3:0]  ecnt [3];
  logic [15:0] tcnt [3];
  logic [15:0] hold [3];
  logic [7:0]  gcnt [3];
  logic [9:0]  ucnt [3];
  logic [2:0]  valid;
  logic [2:0]  seen;
  logic [2:0]  pwm_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 3; i++) begin
        tst[i]     <= FPRT_T_WAIT;
        ecnt[i]    <= '0;
        tcnt[i]    <= '0;
        hold[i]    <= '0;
        gcnt[i]    <= '0;
        ucnt[i]    <= '0;
        reading[i] <= '0;
      end
      valid <= '0;
      seen  <= '0;
      pwm_q <= '0;
    end else begin
      pwm_q <= o_pwm;
      for (int i = 0; i < 3; i++) begin
        logic m2;
        logic win;
        logic [1:0] md;
        m2  = topt[i][`FPRT_TO_MODE2];
        win = !m2 || o_pwm[i];
        md  = tmode[7-2*i -: 2];
        if (ms_tick) begin
          ucnt[i] <= ucnt[i] + 10'd1;
        end
        unique case (tst[i])
          FPRT_T_WAIT: begin
            ecnt[i] <= '0;
            tcnt[i] <= '0;
            gcnt[i] <= '0;
            if (!m2) begin
              tst[i] <= FPRT_T_MEAS;
            end else if (o_pwm[i] && !pwm_q[i]) begin
              tst[i] <= FPRT_T_GUARD;
            end
          end
          FPRT_T_GUARD: begin
            if (!win) begin
              tst[i] <= FPRT_T_WAIT;
            end else if (tk_tick) begin
              gcnt[i] <= gcnt[i] + 8'd1;
              if (gcnt[i] == 8'(GUARD_TKS - 1)) begin
                tst[i] <= FPRT_T_MEAS;
              end
            end
          end
          FPRT_T_MEAS: begin
            if (!win) begin
              tst[i] <= FPRT_T_WAIT;
            end else begin
              if (tk_tick && ecnt[i] >= 4'd2 && tcnt[i] != 16'hffff)
              begin
                tcnt[i] <= tcnt[i] + 16'd1;
              end
              if (tach_edge[i]) begin
                seen[i] <= 1'b1;
                ecnt[i] <= ecnt[i] + 4'd1;
                // first edge is skipped; the second edge opens the span
                if (ecnt[i] == span(topt[i][`FPRT_TO_EDGE+:2])) begin
                  if (topt[i][`FPRT_TO_OPP]) begin
                    reading[i] <= tcnt[i];
                    ucnt[i]    <= '0;
                    seen[i]    <= 1'b0;
                    tst[i]     <= FPRT_T_WAIT;
                  end else begin
                    hold[i]  <= tcnt[i];
                    valid[i] <= 1'b1;
                    tst[i]   <= FPRT_T_DONE;
                  end
                end
              end
            end
          end
          FPRT_T_DONE: begin
            ecnt[i] <= '0;
          end
        endcase
        if (ms_tick && ucnt[i] >= upd_ms(topt[i][`FPRT_TO_UPD+:2]) - 10'd1)
        begin
          ucnt[i]  <= '0;
          valid[i] <= 1'b0;
          seen[i]  <= 1'b0;
          tst[i]   <= FPRT_T_WAIT;
          if (md == 2'b01 || md == 2'b10) begin
            reading[i] <= (tach_q[i] == md[0]) ?
                          `FPRT_RD_STOP : '0;
          end else if (valid[i]) begin
            reading[i] <= hold[i];
          end else begin
            // slow versus stopped
            reading[i] <= (seen[i] && topt[i][`FPRT_TO_SLOW]) ?
                          `FPRT_RD_SLOW : `FPRT_RD_STOP;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave
  logic       acc;
  logic       wr;
  logic [7:0] idx;
  logic       hit;
  logic [7:0] wb;
  logic [31:0] rd;

  assign acc = i_psel && i_penable && !o_pready;
  assign wr  = i_psel && i_penable && o_pready && i_pwrite;
  assign idx = i_paddr[9:2];
  assign wb  = i_pwdata[7:0];

  always_comb begin
    rd  = '0;
    hit = (i_paddr[1:0] == 2'b00) && (i_paddr[11:10] == 2'b00);
    unique case (idx)
      `FPRT_IDX_SEC:   rd[7:0] = sec_stat;
      `FPRT_IDX_TMODE: rd[7:0] = {tmode[7:2], 2'b00};
      `FPRT_IDX_TEST:  rd[7:0] = `FPRT_TEST_VAL;
      `FPRT_IDX_TOPZ1: rd[7:0] = top[0];
      `FPRT_IDX_TOPZ2: rd[7:0] = top[1];
      `FPRT_IDX_TOPZ3: rd[7:0] = top[2];
      `FPRT_IDX_FSTAT: rd[2:0] = fstat;
      default: begin
        hit = 1'b0;
        for (int i = 0; i < 3; i++) begin
          if (idx == `FPRT_IDX_TOPT + 8'(i)) begin
            rd[7:0] = topt[i];
            hit = i_paddr[1:0] == 2'b00;
          end
          if (idx == `FPRT_IDX_POPT + 8'(i)) begin
            rd[7:0] = popt[i];
            hit = i_paddr[1:0] == 2'b00;
          end
          if (idx == `FPRT_IDX_READ + 8'(i)) begin
            rd[15:0] = reading[i];
            hit = i_paddr[1:0] == 2'b00;
          end
          if (idx == `FPRT_IDX_LIMIT + 8'(i)) begin
            rd[15:0] = limit[i];
            hit = i_paddr[1:0] == 2'b00;
          end
          if (idx == `FPRT_IDX_DUTY + 8'(i)) begin
            rd[7:0] = ramp[i];
            hit = i_paddr[1:0] == 2'b00;
          end
        end
        if (i_paddr[11:10] != 2'b00) begin
          hit = 1'b0;
          rd  = '0;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc && !hit;
      o_prdata  <= (acc && !i_pwrite && hit) ? rd : '0;
    end
  end

  // configuration registers; test register takes no write
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tmode <= `FPRT_RST_TMODE;
      for (int i = 0; i < 3; i++) begin
        top[i]   <= `FPRT_RST_TOP;
        topt[i]  <= '0;
        popt[i]  <= '0;
        limit[i] <= `FPRT_RST_LIMIT;
      end
    end else begin
      if (wr && idx == `FPRT_IDX_TMODE) begin
        tmode <= {wb[7:2], 2'b00};
      end
      if (wr && idx == `FPRT_IDX_TOPZ1) top[0] <= wb;
      if (wr && idx == `FPRT_IDX_TOPZ2) top[1] <= wb;
      if (wr && idx == `FPRT_IDX_TOPZ3) top[2] <= wb;
      for (int i = 0; i < 3; i++) begin
        if (wr && idx == `FPRT_IDX_TOPT + 8'(i)) topt[i] <= wb;
        if (wr && idx == `FPRT_IDX_POPT + 8'(i)) popt[i] <= wb;
        if (wr && idx == `FPRT_IDX_LIMIT + 8'(i)) begin
          limit[i] <= i_pwdata[15:0];
        end
        if (pg_rise) top[i] <= `FPRT_RST_TOP;
      end
    end
  end

  // sticky status; set wins over a written clear, power-good rise clears sec_stat; no interrupt pin
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sec_stat <= `FPRT_RST_SEC;
      fstat    <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr && idx == `FPRT_IDX_FSTAT && wb[i]) begin
          fstat[i] <= 1'b0;
        end
        if (topt[i][`FPRT_TO_SEN] && reading[i] > limit[i]) begin
          fstat[i] <= 1'b1;
        end
      end
      if (wr && idx == `FPRT_IDX_SEC) begin
        // clear only once the cause has gone
        if (wb[`FPRT_SEC_BATT] && !bat_lv) begin
          sec_stat[`FPRT_SEC_BATT] <= 1'b0;
        end
        if (wb[`FPRT_SEC_STBY] && !stb_lv) begin
          sec_stat[`FPRT_SEC_STBY] <= 1'b0;
        end
      end
      if (bat_lv) sec_stat[`FPRT_SEC_BATT] <= 1'b1;
      if (stb_lv) sec_stat[`FPRT_SEC_STBY] <= 1'b1;
      if (pg_rise) sec_stat <= `FPRT_RST_SEC;
    end
  end

endmodule

// File: tb/fan_pwm_ramp_and_tach_monitor_bench.sv
// Purpose: self-checking bench of the fan pwm ramp and tach monitor
// Assumes: short ms tick, one pwm count per cycle, one guard tick
// Notes:   tach 0 measured; tach edges every 277 cycles (1 tick)
`timescale 1ns/1ns
module fan_pwm_ramp_and_tach_monitor_bench;
  import fprt_pkg::*;
  localparam int MS = 5;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        pg, batt, stby, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  tach, pwm, spin;
  fprt_byte_t  tgt [3];
  int          error_cnt, n_compared, d, hi;
  int          mdl [256];
  byte unsigned idx [6] = '{8'ha7, 8'hab, 8'had, 8'hae, 8'haf, 8'hb3};
  int          stp [8] = '{206, 104, 69, 41, 26, 18, 10, 5};
  int          span [4] = '{2, 3, 5, 9};
  fprt_top #(.MS_CYC(MS), .PWM_DIV(1), .GUARD_TKS(1)) DUT (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_target_duty(tgt), .i_tach(tach),
    .o_pwm(pwm), .i_supply_power_good(pg), .i_batt_event(batt),
    .i_standby_supply_event(stby));
  fprt_fan_model #(.HALF(277)) fan [2:0] (
    .i_clk(clk), .i_pwm(pwm), .i_spin(spin), .o_tach(tach));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, lo, hi);
    n_compared++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 0);
    chk(rd, e, e);
  endtask
  // write that also updates the expected register image
  task automatic wrm(input logic [7:0] a, input int v);
    apb(1'b1, a, v);
    case (a)
      8'hab: mdl[a] = v & 32'hfc;
      8'hae, 8'haf, 8'hb3: mdl[a] = v & 32'hff;
      default: ;
    endcase
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    wrap_up();
  end
  initial begin
    error_cnt = 0;
    n_compared = 0;
    {arst_n, psel, penable, pwrite, pg, batt, stby} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    spin = 3'h0;
    tgt = '{8'h00, 8'h00, 8'h00};
    foreach (mdl[i]) mdl[i] = 0;
    for (int i = 3; i < 6; i++) mdl[idx[i]] = 32'h2d;
    void'($urandom(70912));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    tgt[1] <= 8'($urandom);
    tgt[2] <= 8'($urandom);
    spin <= {2'($urandom), 1'b0};
    @(posedge clk);
    foreach (idx[i]) rdc(idx[i], mdl[idx[i]]);
    apb(1'b0, 8'h10, 0);
    chk({31'h0, err}, 1, 1);
    foreach (idx[i]) begin
      wrm(idx[i], $urandom);
      rdc(idx[i], mdl[idx[i]]);
    end
    for (int c = 0; c < 4; c++) begin
      wrm(8'hab, {c[1:0], c[1:0], c[1:0], 2'b11});
      rdc(8'hab, mdl[8'hab]);
    end
    wrm(8'hab, 0);
    pg <= 1'b1;
    repeat (12) @(posedge clk);
    for (int i = 3; i < 6; i++) mdl[idx[i]] = 32'h2d;
    foreach (idx[i]) rdc(idx[i], mdl[idx[i]]);
    batt <= 1'b1;
    stby <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(8'ha7, 3);
    apb(1'b1, 8'ha7, 32'hff);
    rdc(8'ha7, 3);
    batt <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b1, 8'ha7, 0);
    rdc(8'ha7, 3);
    apb(1'b1, 8'ha7, 2);
    rdc(8'ha7, 1);
    stby <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b1, 8'ha7, 1);
    rdc(8'ha7, 0);
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, 8'h94, r);
      tgt[0] <= 8'h00;
      repeat (3) @(posedge clk);
      tgt[0] <= 8'h01;
      repeat (3) @(posedge clk);
      rdc(8'h68, 1);
      tgt[0] <= 8'hff;
      repeat (8 * stp[r] * MS + 510) @(posedge clk);
      apb(1'b0, 8'h68, 0);
      chk(rd, 7, 11 + 510 / (stp[r] * MS));
    end
    d = rd + 3;
    tgt[0] <= 8'(d);
    repeat (600) @(posedge clk);
    rdc(8'h68, d);
    hi = 0;
    repeat (255) begin
      @(posedge clk);
      hi += pwm[0];
    end
    chk(hi, d, d);
    apb(1'b1, 8'h94, 8'h0f);
    tgt[0] <= 8'h00;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h68, 0);
    chk(rd, 1, d);
    repeat (1500) @(posedge clk);
    rdc(8'h68, 0);
    tgt[0] <= 8'd40;
    repeat (300) @(posedge clk);
    apb(1'b1, 8'h94, 8'h07);
    tgt[0] <= 8'h00;
    repeat (3) @(posedge clk);
    rdc(8'h68, 0);
    tgt[0] <= 8'hff;
    spin[0] <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 8'h90, (s < 3 ? 32'h20 : 32'h50) | (s << 1));
      repeat (s < 3 ? 5000 : 10000) @(posedge clk);
      apb(1'b0, 8'h60, 0);
      chk(rd, span[s] - 2, span[s]);
    end
    spin[0] <= 1'b0;
    apb(1'b1, 8'h64, 32'h100);
    apb(1'b1, 8'h90, 32'hc0);
    repeat (10000) @(posedge clk);
    rdc(8'h60, 32'hffff);
    apb(1'b0, 8'h6c, 0);
    chk(rd & 1, 1, 1);
    // locked rotor: exactly one polarity reports ffff
    wrm(8'hab, 32'h40);
    repeat (5010) @(posedge clk);
    apb(1'b0, 8'h60, 0);
    d = rd;
    wrm(8'hab, 32'h80);
    repeat (5010) @(posedge clk);
    apb(1'b0, 8'h60, 0);
    chk(d + rd, 32'hffff, 32'hffff);
    wrm(8'hab, 0);
    tgt[0] <= 8'h00;
    spin[0] <= 1'b1;
    apb(1'b1, 8'h90, 32'h48);
    repeat (10000) @(posedge clk);
    rdc(8'h60, 32'hffff);
    wrap_up();
  end
endmodule
bind fprt_top fprt_props #(.PWM_DIV(PWM_DIV)) u_props (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_target_duty(i_target_duty), .o_pwm(o_pwm),
  .i_supply_power_good(i_supply_power_good), .i_batt_event(i_batt_event));

// File: tb/fprt_fan_model.sv
// Purpose: three-wire fan with tach output
// Assumes: fan powered only while its pwm is high
// Notes:   unpowered tach floats, shown as a toggling line
`timescale 1ns/1ns
module fprt_fan_model #(
  parameter int HALF = 554
) (
  input  wire logic i_clk,
  input  wire logic i_pwm,
  input  wire logic i_spin,
  output logic      o_tach
);
  int   cnt;
  int   jc;
  logic lvl;
  logic junk;
  initial begin
    cnt = 0;
    jc = 0;
    lvl = 1'b0;
    junk = 1'b0;
  end
  always @(posedge i_clk) begin
    // slow noise, survives the input filter
    jc <= (jc == 49) ? 0 : jc + 1;
    if (jc == 49) junk <= ~junk;
    if (i_pwm && i_spin) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) lvl <= ~lvl;
    end
  end
  assign o_tach = i_pwm ? lvl : junk;
endmodule

// File: tb/fprt_props.sv
// Purpose: port-level checks of the fan pwm ramp and tach monitor
// Assumes: bound to fprt_top; pwm 0 is the watched channel
// Notes:   byte address = 4 * register index
`timescale 1ns/1ns
module fprt_props #(
  parameter int PWM_DIV = 4
) (
  input wire logic                 i_core_clk,
  input wire logic                 i_arst_n,
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 i_pwrite,
  input wire logic [11:0]          i_paddr,
  input wire logic [31:0]          o_prdata,
  input wire logic                 o_pready,
  input wire logic                 o_pslverr,
  input wire fprt_pkg::fprt_byte_t i_target_duty [3],
  input wire logic [2:0]           o_pwm,
  input wire logic                 i_supply_power_good,
  input wire logic                 i_batt_event
);
  import fprt_pkg::*;
  localparam int PER  = 255 * PWM_DIV;
  localparam int PWIN = 255 * PWM_DIV + 4;
  logic rd_cyc;
  int   since_rise;
  logic seen_rise;
  int   pg_age;
  logic top_wr;
  assign rd_cyc = o_pready && i_psel && !i_pwrite;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////
  // cycles since the last pwm 0 rise
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      since_rise <= 0;
      seen_rise <= 1'b0;
    end else begin
      since_rise <= $rose(o_pwm[0]) ? 0 : since_rise + 1;
      if ($rose(o_pwm[0])) seen_rise <= 1'b1;
    end
  end
  // age of the last power-good rise, untouched zone 1 limit
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pg_age <= 0;
      top_wr <= 1'b1;
    end else begin
      if ($rose(i_supply_power_good)) pg_age <= 0;
      else if (pg_age < 16) pg_age <= pg_age + 1;
      if ($rose(i_supply_power_good)) top_wr <= 1'b0;
      if (i_psel && i_pwrite && i_paddr == 12'h2b8) top_wr <= 1'b1;
    end
  end
  ////////////////////////////////////////
  AST_ANSWER_TIME:
    assert property ($rose(i_penable) && i_psel |=> o_pready)
    else $error("no ready one cycle after access");
  AST_READY_PULSE:
    assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_ERR_SHAPE:
    assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error without ready or with data");
  AST_RESET_OFF:
    assert property ($rose(i_arst_n) |-> o_pwm == 3'h0 && !o_pready)
    else $error("outputs active after reset");
  AST_PERIOD_START:
    assert property ($rose(o_pwm[0]) && seen_rise
      |-> (since_rise % PER) == PER - 1)
    else $error("pwm rise off the period start");
  AST_DIRECT_LOAD:
    assert property ($past(i_target_duty[0]) == 8'h00
      && i_target_duty[0] != 8'h00 |-> ##[1:PWIN] o_pwm[0])
    else $error("pwm not on within a period of leaving zero");
  AST_MODE_LOW_BITS:
    assert property (rd_cyc && i_paddr == 12'h2ac
      |-> o_prdata[1:0] == 2'h0 && o_prdata[31:8] == 24'h0)
    else $error("mode reserved bits not zero");
  AST_TEST_ZERO:
    assert property (rd_cyc && i_paddr == 12'h2b4
      |-> o_prdata == 32'h0 && !o_pslverr)
    else $error("test register not zero");
  AST_BATT_FLAG:
    assert property (i_batt_event [*8] ##0 (rd_cyc && i_paddr == 12'h29c)
      |-> o_prdata[1] && o_prdata[31:2] == 30'h0)
    else $error("battery flag missing");
  AST_TOP_DEFAULT:
    assert property (rd_cyc && i_paddr == 12'h2b8 && pg_age >= 8 && !top_wr
      |-> o_prdata == 32'h2d)
    else $error("zone 1 limit not default after power good");
endmodule
